// ---- power_mode_defines.vh ----
// Constants for the power mode controller: APB offsets, field positions,
// reset values and timing counts. Included by power_mode_controller.v.
`ifndef POWER_MODE_DEFINES_VH
`define POWER_MODE_DEFINES_VH

`define PMC_CTRL_OFFSET    12'h000
`define PMC_SLEEP_OFFSET   12'h004
`define PMC_STATUS_OFFSET  12'h008
`define PMC_CLKSEL_OFFSET  12'h00c

`define PMC_CTRL_IDLE_BIT  0
`define PMC_SLEEP_MODE_LSB 0
`define PMC_SLEEP_MODE_MSB 1
`define PMC_SLEEP_USB_BIT  7
`define PMC_CLKSEL_OSC_BIT 0
`define PMC_CLKSEL_32K_BIT 1

`define PMC_SLEEP_RESET    8'h00
`define PMC_CLKSEL_RESET   8'h01

`define PMC_CLK_HZ         10000000
`define PMC_PWRUP_NS       2000
`define PMC_PWRUP_CYCLES   ((`PMC_PWRUP_NS * (`PMC_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ---- power_mode_controller.v ----
// Power mode controller: active mode plus four sleep modes, APB registers,
// clock gating, oscillator and regulator enables, usb reset and wake logic.
// Assumes wake pins are asynchronous; interrupt requests come from same-clock logic.
`include "power_mode_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module power_mode_controller #(
  parameter PWRUP_CYCLES = `PMC_PWRUP_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        port_wake_pin,
  input  wire        sleep_timer_irq,
  input  wire        cpu_irq,
  input  wire        crystal_stable_flag,
  output reg         cpu_clk_en,
  output reg         fast_rc_oscillator_en,
  output reg         crystal_oscillator_en,
  output reg         slow_osc_en,
  output reg         regulator_en,
  output reg         usb_reset,
  output reg         sysclk_from_crystal,
  output reg         resume_wake,
  output reg         port_irq_out,
  output reg         timer_irq_out
);

  localparam [5:0] ST_ACTIVE = 6'h01;
  localparam [5:0] ST_MODE0  = 6'h02;
  localparam [5:0] ST_MODE1  = 6'h04;
  localparam [5:0] ST_MODE2  = 6'h08;
  localparam [5:0] ST_MODE3  = 6'h10;
  localparam [5:0] ST_WAKE   = 6'h20;

  reg  [5:0]  state_r;
  reg  [5:0]  state_nxt;
  reg  [7:0]  sleep_r;
  reg  [7:0]  clksel_r;
  reg         xtal_on_r;
  reg  [15:0] wake_cnt_r;
  reg         resume_r;
  reg  [2:0]  pin_sync_r;
  reg         pin_lvl_r;
  reg         pin_lvl_d_r;
  reg  [2:0]  stb_sync_r;
  reg         stb_r;

  wire [1:0]  mode_sel   = sleep_r[`PMC_SLEEP_MODE_MSB:`PMC_SLEEP_MODE_LSB];
  wire        apb_access = psel & penable & pready;
  wire        apb_wr     = apb_access & pwrite;
  wire        idle_wr    = apb_wr & (paddr == `PMC_CTRL_OFFSET) & pwdata[`PMC_CTRL_IDLE_BIT];
  wire        pin_wake   = pin_lvl_r & ~pin_lvl_d_r;
  wire        sleeping   = state_r[2] | state_r[3] | state_r[4];
  // Pin and timer requests pass only while the sleep mode field is clear
  wire        int_gate   = (mode_sel == 2'b00);
  wire        irq_any    = cpu_irq | ((pin_wake | sleep_timer_irq) & int_gate);
  wire        crystal_sel = ~clksel_r[`PMC_CLKSEL_OSC_BIT];

  // Pin wake sampled with three flops; change counts when the last two agree
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_sync_r  <= 3'h0;
      pin_lvl_r   <= 1'b0;
      pin_lvl_d_r <= 1'b0;
      stb_sync_r  <= 3'h0;
      stb_r       <= 1'b0;
    end else begin
      pin_sync_r  <= {pin_sync_r[1:0], port_wake_pin};
      stb_sync_r  <= {stb_sync_r[1:0], crystal_stable_flag};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_lvl_r <= pin_sync_r[2];
      if (stb_sync_r[1] == stb_sync_r[2])
        stb_r <= stb_sync_r[2];
      pin_lvl_d_r <= pin_lvl_r;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (idle_wr) begin
          case (mode_sel)
            2'd0:    state_nxt = ST_MODE0;
            2'd1:    state_nxt = ST_MODE1;
            2'd2:    state_nxt = ST_MODE2;
            default: state_nxt = ST_MODE3;
          endcase
        end
      end
      ST_MODE0: begin
        if (cpu_irq | pin_wake | sleep_timer_irq)
          state_nxt = ST_ACTIVE;
      end
      ST_MODE1, ST_MODE2: begin
        if (pin_wake | sleep_timer_irq)
          state_nxt = ST_WAKE;
      end
      ST_MODE3: begin
        if (pin_wake)
          state_nxt = ST_WAKE;
      end
      ST_WAKE: begin
        if (wake_cnt_r == 16'h0000)
          state_nxt = ST_ACTIVE;
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  // Reset forces active mode and a program restart rather than resume
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r    <= ST_ACTIVE;
      sleep_r    <= `PMC_SLEEP_RESET;
      clksel_r   <= `PMC_CLKSEL_RESET;
      wake_cnt_r <= 16'h0000;
      resume_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_ACTIVE && state_nxt != ST_ACTIVE)
        sleep_r[`PMC_SLEEP_MODE_MSB:`PMC_SLEEP_MODE_LSB] <= 2'b00;
      else if (apb_wr && paddr == `PMC_SLEEP_OFFSET)
        sleep_r <= pwdata[7:0];
      if (apb_wr && paddr == `PMC_CLKSEL_OFFSET)
        clksel_r <= pwdata[7:0];
      if (sleeping && state_nxt == ST_WAKE)
        wake_cnt_r <= PWRUP_CYCLES[15:0];
      else if (wake_cnt_r != 16'h0000)
        wake_cnt_r <= wake_cnt_r - 16'h0001;
      // One-cycle flag: back in active by wake, continue where stopped
      resume_r <= (state_r != ST_ACTIVE) && (state_nxt == ST_ACTIVE);
    end
  end

  // Crystal settles after wake; until then the fast rc clocks the system
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      xtal_on_r <= 1'b0;
    else if (state_r == ST_WAKE || !crystal_sel)
      xtal_on_r <= 1'b0;
    else if (stb_r)
      xtal_on_r <= 1'b1;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en            <= 1'b1;
      fast_rc_oscillator_en <= 1'b1;
      crystal_oscillator_en <= 1'b0;
      slow_osc_en           <= 1'b1;
      regulator_en          <= 1'b1;
      usb_reset             <= 1'b0;
      sysclk_from_crystal   <= 1'b0;
      resume_wake           <= 1'b0;
      port_irq_out          <= 1'b0;
      timer_irq_out         <= 1'b0;
    end else begin
      cpu_clk_en            <= state_r[0];
      fast_rc_oscillator_en <= state_r[0] | state_r[1] | state_r[5];
      crystal_oscillator_en <= crystal_sel & (state_r[0] | state_r[1] | state_r[5]);
      slow_osc_en           <= ~state_r[4];
      regulator_en          <= ~(state_r[3] | state_r[4]);
      usb_reset             <= state_r[3] | state_r[4] | ~sleep_r[`PMC_SLEEP_USB_BIT];
      sysclk_from_crystal   <= xtal_on_r & crystal_sel & state_r[0];
      resume_wake           <= resume_r;
      port_irq_out          <= pin_wake & int_gate;
      timer_irq_out         <= sleep_timer_irq & int_gate;
    end
  end

  // APB slave: one wait state, unmapped addresses answer with an error
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready) begin
        case (paddr)
          `PMC_CTRL_OFFSET:   prdata <= 32'h00000000;
          `PMC_SLEEP_OFFSET:  prdata <= {24'h000000, sleep_r};
          `PMC_STATUS_OFFSET: prdata <= {24'h000000, 1'b0, irq_any, stb_r, resume_r, state_r[4:1]};
          `PMC_CLKSEL_OFFSET: prdata <= {24'h000000, clksel_r};
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- power_mode_controller_properties.sv ----
// Port checker for the power mode controller.
// Bound to every power_mode_controller instance; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module pmc_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_clk_en,
  input wire logic fast_rc_oscillator_en,
  input wire logic crystal_oscillator_en,
  input wire logic slow_osc_en,
  input wire logic regulator_en,
  input wire logic usb_reset,
  input wire logic sysclk_from_crystal,
  input wire logic resume_wake
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_APB_ACK: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside an access or longer than one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ACTIVE: assert property (cpu_clk_en |-> regulator_en && slow_osc_en && fast_rc_oscillator_en)
    else $error("cpu running without its clocks or regulator");
  AST_FAST_OFF: assert property (!fast_rc_oscillator_en |-> !cpu_clk_en && !crystal_oscillator_en)
    else $error("fast oscillators not both stopped");
  AST_DEEP: assert property (!slow_osc_en |-> !regulator_en && !fast_rc_oscillator_en)
    else $error("deepest mode with something still on");
  AST_USB: assert property (!regulator_en |-> usb_reset)
    else $error("usb state kept with regulator off");
  AST_XTAL: assert property (sysclk_from_crystal |-> crystal_oscillator_en && cpu_clk_en)
    else $error("system clock on a stopped crystal");
  AST_RESUME: assert property (resume_wake |=> !resume_wake && cpu_clk_en)
    else $error("resume not a single pulse in active mode");
endmodule
bind power_mode_controller pmc_props i_props (.*);
`default_nettype wire

// ---- test_power_mode_controller.sv ----
// Self-checking bench for the power mode controller: modes, wakes, APB.
// Drives every port itself; power-up count shortened to 2.
`timescale 1ns/100ps
`default_nettype none
module test_power_mode_controller;
  logic        core_clk = '0, rst = 1'b1, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er, pin = '0, tmr = '0, cirq = '0, xst = '0;
  logic        cpu, frc, xo, slo, reg_en, usbr, sxc, rsm, pio, tio;
  integer      error_cnt = 0, compares = 0, seed = 32'h3e86, m, n, k, usb;
  power_mode_controller #(.PWRUP_CYCLES(2)) i_dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_wake_pin(pin), .sleep_timer_irq(tmr), .cpu_irq(cirq), .crystal_stable_flag(xst),
    .cpu_clk_en(cpu), .fast_rc_oscillator_en(frc), .crystal_oscillator_en(xo),
    .slow_osc_en(slo), .regulator_en(reg_en), .usb_reset(usbr),
    .sysclk_from_crystal(sxc), .resume_wake(rsm), .port_irq_out(pio), .timer_irq_out(tio));
  initial forever #50 core_clk = ~core_clk;
  task chk(input string s, input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 9) chk("pready", pready, 1);
  endtask
  task tally_and_finish;
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    chk("reset outs", {cpu, frc, xo, slo, reg_en, usbr, rsm}, 7'b1101100);
    apb(0, 12'h000, 0);
    chk("idle read", rd, 0);
    apb(0, 12'h040, 0);
    chk("unmapped err", {31'h0, er}, 1);
    chk("unmapped data", rd, 0);
    for (k = 0; k < 2; k++) begin
      apb(1, 12'h004, k);
      tmr <= 1'b1;
      pin <= 1'b1;
      @(posedge core_clk) tmr <= 1'b0;
      n = 0;
      m = 0;
      repeat (6) @(posedge core_clk) begin
        n = n | tio;
        m = m | pio;
      end
      pin <= 1'b0;
      repeat (5) @(posedge core_clk);
      chk("timer irq out", n, k == 0);
      chk("port irq out", m, k == 0);
    end
    apb(1, 12'h00c, 0);
    for (m = 0; m < 4; m++) begin
      usb = $random(seed) & 1;
      apb(1, 12'h004, ($random(seed) & 32'hffffff00) | (usb << 7) | m);
      apb(1, 12'h000, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("sleep outs", {cpu, frc, slo, reg_en, usbr}, {1'b0, m == 0, m != 3, m < 2, m > 1 || !usb});
      if (m == 3) begin
        tmr <= 1'b1;
        @(posedge core_clk) tmr <= 1'b0;
        repeat (9) @(posedge core_clk);
        chk("deep asleep", cpu, 0);
      end
      if (m == 0) cirq <= 1'b1;
      else if (m == 2) tmr <= 1'b1;
      else pin <= 1'b1;
      @(posedge core_clk) cirq <= 1'b0;
      tmr <= 1'b0;
      n = 0;
      k = 0;
      while (cpu !== 1'b1 && n < 60) begin
        @(posedge core_clk);
        n++;
        k = k | rsm;
      end
      repeat (3) @(posedge core_clk) k = k | rsm;
      pin <= 1'b0;
      chk("woke", cpu, 1);
      if (m > 0) chk("resume and rc clock", {k[0], sxc}, 2'b10);
      apb(0, 12'h004, 0);
      chk("mode field", rd & 32'h83, usb << 7);
    end
    xst <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("crystal clock", sxc, 1);
    apb(1, 12'h004, 2);
    apb(1, 12'h000, 1);
    repeat (3) @(posedge core_clk) rst <= 1'b1;
    @(posedge core_clk);
    chk("reset in sleep", {cpu, reg_en}, 2'b11);
    rst <= 1'b0;
    k = 0;
    repeat (10) @(posedge core_clk) k = k | rsm;
    chk("restart", {cpu, k[0]}, 2'b10);
    tally_and_finish;
  end
endmodule
`default_nettype wire
